// file: src/eiq_top.sv
`timescale 1ns/1ps
`include "eiq_map.svh"

module eiq_top (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // Register port
   input  wire eiq_pkg::eiq_bus_req_t bus_req,
   output logic [31:0]                bus_rdata,
   // Controller events
   input  wire eiq_pkg::eiq_evt_t     evt,
   input  wire logic [7:0]            rx_desc_used,
   // Status outputs
   output logic                       irq,
   output logic                       rx_halt,
   output logic                       module_on
);
   import eiq_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   logic       wr_flags;
   logic       wr_clr;
   logic       wr_set;
   logic       wr_inv;
   logic       wr_ien;
   logic       wr_stat;
   logic       wr_ctl;
   logic       wr_rxst;
   logic       wr_drop;
   logic       rd_drop_clr;
   logic       dec;
   logic       inc;
   logic [7:0] wmask;

   assign wr_flags = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_FLAGS);
   assign wr_clr   = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_CLR);
   assign wr_set   = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_SET);
   assign wr_inv   = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_INV);
   assign wr_ien   = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_IEN);
   assign wr_stat  = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_STAT);
   assign wr_ctl   = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_CTL);
   assign wr_rxst  = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_RXST);
   assign wr_drop  = bus_req.wr & hit(bus_req.addr, `EIQ_OFF_DROP);
   // Reads with both low lanes off leave the counter alone
   assign rd_drop_clr = bus_req.rd & hit(bus_req.addr, `EIQ_OFF_DROP)
                      & (|bus_req.be[1:0]);
   assign dec   = wr_ctl & bus_req.wdata[`EIQ_CTL_DEC];
   assign inc   = evt.rx_pkt_done;
   assign wmask = bus_req.wdata[7:0] & `EIQ_FLAG_MASK;

   // ****************************************
   // Control and enables
   // ****************************************
   logic        ctl_flow;
   logic [7:0]  ien;
   logic [31:0] rxst;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         module_on <= 1'b0;
         ctl_flow  <= 1'b0;
      end else if (wr_ctl) begin
         module_on <= bus_req.wdata[`EIQ_CTL_ON];
         ctl_flow  <= bus_req.wdata[`EIQ_CTL_FLOW];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ien <= `EIQ_RST_8;
      end else if (wr_ien) begin
         ien <= bus_req.wdata[7:0] & `EIQ_IEN_MASK;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxst <= `EIQ_RST_32;
      end else if (wr_rxst) begin
         rxst <= bus_req.wdata;
      end
   end

   // ****************************************
   // Event flags
   // ****************************************
   logic [7:0] flags;
   logic [7:0] next_flags;
   logic [7:0] set_evt;
   logic [7:0] shown;

   always_comb begin
      set_evt = `EIQ_RST_8;
      set_evt[`EIQ_B_RX_ACTIVITY_FLAG]  = evt.rx_data_stored;
      set_evt[`EIQ_B_TX_COMPLETE_FLAG] = evt.tx_done;
      set_evt[`EIQ_B_TXABN]  = evt.tx_abandon;
      set_evt[`EIQ_B_BUFNA]  = evt.rx_desc_overrun;
      set_evt[`EIQ_B_OVF]    = evt.rx_fifo_overflow | evt.rx_frame_dropped;
   end

   // Hardware events are OR-ed last so that a set wins over a clear
   always_comb begin
      next_flags = flags;
      if (wr_flags) begin
         next_flags = wmask;
      end
      if (wr_clr) begin
         next_flags = flags & ~wmask;
      end
      if (wr_set) begin
         next_flags = flags | wmask;
      end
      if (wr_inv) begin
         next_flags = flags ^ wmask;
      end
      next_flags = next_flags | set_evt;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags <= `EIQ_RST_8;
      end else begin
         flags <= next_flags;
      end
   end

   // ****************************************
   // Received buffer count
   // ****************************************
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [8:0] sum;

   assign sum = {1'b0, cnt} + {1'b0, rx_desc_used};

   // Module off does not touch the count; software may still drain it
   always_comb begin
      next_cnt = cnt;
      if (inc && dec) begin
         next_cnt = cnt;
      end else if (inc) begin
         next_cnt = sum[8] ? `EIQ_CNT_MAX : sum[7:0];
      end else if (dec && cnt != `EIQ_RST_8) begin
         next_cnt = cnt - 8'h01;
      end
      if (wr_stat) begin
         next_cnt = bus_req.wdata[23:16];
      end
      if (wr_rxst) begin
         next_cnt = `EIQ_RST_8;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= `EIQ_RST_8;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Stall lasts only while flow control is on and the count is full
   assign rx_halt = ctl_flow & (cnt == `EIQ_CNT_MAX);

   // ****************************************
   // Dropped frame counter
   // ****************************************
   logic [15:0] drop;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drop <= `EIQ_RST_16;
      end else if (rd_drop_clr) begin
         drop <= {15'h0000, evt.rx_frame_dropped};
      end else if (wr_drop) begin
         drop <= bus_req.wdata[15:0];
      end else if (evt.rx_frame_dropped) begin
         drop <= drop + 16'h0001;
      end
   end

   // ****************************************
   // Status and interrupt
   // ****************************************
   logic [7:0] stat;

   always_comb begin
      shown = flags;
      shown[`EIQ_B_PEND] = (cnt != `EIQ_RST_8);
      stat = `EIQ_RST_8;
      stat[`EIQ_ST_MOD] = module_on | evt.txn_pending;
      stat[`EIQ_ST_TX]  = module_on & evt.tx_busy;
      stat[`EIQ_ST_RX]  = module_on & evt.rx_busy;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(shown & ien);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= `EIQ_RST_32;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            `EIQ_OFF_FLAGS: bus_rdata <= {24'h000000, shown};
            `EIQ_OFF_IEN:   bus_rdata <= {24'h000000, ien};
            `EIQ_OFF_STAT:  bus_rdata <= {8'h00, cnt, 8'h00, stat};
            `EIQ_OFF_DROP:  bus_rdata <= {16'h0000, drop};
            `EIQ_OFF_CTL:   bus_rdata <= {16'h0000, module_on, 10'h000, ctl_flow, 4'h0};
            `EIQ_OFF_RXST:  bus_rdata <= rxst;
            default:        bus_rdata <= `EIQ_RST_32;
         endcase
      end else begin
         bus_rdata <= `EIQ_RST_32;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_rd_flags;
      bus_req.rd && bus_req.addr == `EIQ_OFF_FLAGS;
   endsequence
   sequence s_rd_stat;
      bus_req.rd && bus_req.addr == `EIQ_OFF_STAT;
   endsequence

   property p_pend;
      s_rd_flags |=> bus_rdata[6] == ($past(cnt) != 8'h00);
   endproperty
   a_pend: assert property (p_pend) else $error("waiting flag wrong");

   property p_rx_activity_flag;
      evt.rx_data_stored |=> flags[5] ##1 (flags[5] || $past(wr_clr || wr_inv || wr_flags));
   endproperty
   a_rx_activity_flag: assert property (p_rx_activity_flag) else $error("activity flag lost");

   property p_set_wins;
      evt.tx_done && wr_clr && bus_req.wdata[3] |=> flags[3];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat event");

   property p_clr;
      wr_clr && bus_req.wdata[2] && !evt.tx_abandon |=> !flags[2];
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");

   property p_sat;
      inc && !dec && !wr_rxst && !wr_stat && cnt == 8'hff |=> cnt == 8'hff;
   endproperty
   a_sat: assert property (p_sat) else $error("count wrapped up");

   property p_floor;
      dec && !inc && !wr_rxst && !wr_stat && cnt == 8'h00 |=> cnt == 8'h00;
   endproperty
   a_floor: assert property (p_floor) else $error("count wrapped down");

   property p_both;
      inc && dec && !wr_rxst && !wr_stat |=> $stable(cnt);
   endproperty
   a_both: assert property (p_both) else $error("count moved");

   property p_inc;
      inc && !dec && !wr_rxst && !wr_stat && sum[8] == 1'b0 |=> cnt == $past(sum[7:0]);
   endproperty
   a_inc: assert property (p_inc) else $error("count add wrong");

   property p_halt;
      cnt == 8'hff |-> rx_halt == ctl_flow;
   endproperty
   a_halt: assert property (p_halt) else $error("halt wrong");

   property p_rxst;
      wr_rxst |=> cnt == 8'h00;
   endproperty
   a_rxst: assert property (p_rxst) else $error("count not zeroed");

   property p_busy;
      s_rd_stat ##0 !module_on |=> bus_rdata[6:5] == 2'b00;
   endproperty
   a_busy: assert property (p_busy) else $error("busy while off");

   property p_drop;
      rd_drop_clr && !evt.rx_frame_dropped |=> drop == 16'h0000;
   endproperty
   a_drop: assert property (p_drop) else $error("drop not cleared");

   property p_drop_inc;
      evt.rx_frame_dropped && !rd_drop_clr && !wr_drop |=> drop == $past(drop) + 16'h0001 && flags[0];
   endproperty
   a_drop_inc: assert property (p_drop_inc) else $error("drop not counted");

   property p_irq;
      (shown & ien) != 8'h00 |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

endmodule

// file: src/eiq_map.svh
// Operation
// - Packet waiting flag follows nonzero buffer count
// - Receive data stored sets activity flag
// - Finished transmit with status sets done flag
// - Transmit abandon by MAC sets abandon flag
// - Descriptor overrun sets unavailable flag
// - Receive FIFO overflow sets overflow flag
// - Reset or clear alias clears event flags
// - Good packet adds its descriptors to count
// - Count saturates at maximum on increment
// - Decrement at zero leaves count zero
// - Simultaneous increment and decrement keep count
// - Full count halts receive under flow control
// - No flow control: receive continues when full
// - Descriptor start address write zeroes count
// - Module off keeps buffer count
// - Module active while on or finishing
// - Transmit active only while on
// - Receive active only while on
// - Dropped accepted frame counts and sets overflow
// - Dropped counter clears on read, low lanes
// - Each flag gated by its enable bit
`ifndef EIQ_MAP_SVH
`define EIQ_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define EIQ_OFF_FLAGS 8'h00
`define EIQ_OFF_CLR   8'h04
`define EIQ_OFF_SET   8'h08
`define EIQ_OFF_INV   8'h0c
`define EIQ_OFF_IEN   8'h10
`define EIQ_OFF_STAT  8'h14
`define EIQ_OFF_DROP  8'h18
`define EIQ_OFF_CTL   8'h1c
`define EIQ_OFF_RXST  8'h20

// ****************************************
// Fields
// ****************************************
`define EIQ_B_PEND    6
`define EIQ_B_RX_ACTIVITY_FLAG   5
`define EIQ_B_TX_COMPLETE_FLAG  3
`define EIQ_B_TXABN   2
`define EIQ_B_BUFNA   1
`define EIQ_B_OVF     0
`define EIQ_FLAG_MASK 8'h2f
`define EIQ_IEN_MASK  8'h6f
`define EIQ_CTL_ON    15
`define EIQ_CTL_FLOW  4
`define EIQ_CTL_DEC   0
`define EIQ_ST_MOD    7
`define EIQ_ST_TX     6
`define EIQ_ST_RX     5

// ****************************************
// Reset values and limits
// ****************************************
`define EIQ_RST_8     8'h00
`define EIQ_RST_16    16'h0000
`define EIQ_RST_32    32'h0000_0000
`define EIQ_CNT_MAX   8'hff

`endif

// file: src/eiq_pkg.sv
package eiq_pkg;

   // ****************************************
   // Register port request
   // ****************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [3:0]  be;
      logic        wr;
      logic        rd;
   } eiq_bus_req_t;

   // ****************************************
   // Events and levels from the controller
   // ****************************************
   typedef struct packed {
      logic rx_data_stored;
      logic tx_done;
      logic tx_abandon;
      logic rx_desc_overrun;
      logic rx_fifo_overflow;
      logic rx_frame_dropped;
      logic rx_pkt_done;
      logic txn_pending;
      logic tx_busy;
      logic rx_busy;
   } eiq_evt_t;

endpackage

// file: test/eiq_top_test.sv
`timescale 1ns/1ps
`include "eiq_map.svh"

module eiq_top_test;
   import eiq_pkg::*;

   // ********
   // Signals
   // ********
   logic         clock;
   logic         rst_n;
   eiq_bus_req_t bus_req;
   logic [31:0]  bus_rdata;
   eiq_evt_t     evt;
   logic [7:0]   rx_desc_used;
   logic         irq;
   logic         rx_halt;
   logic         module_on;
   logic [2:0]   lvl;
   logic [31:0]  rd_val;
   int           failures;
   int           comparisons;

   eiq_top i_eiq_top (
      .clock        (clock),
      .rst_n        (rst_n),
      .bus_req      (bus_req),
      .bus_rdata    (bus_rdata),
      .evt          (evt),
      .rx_desc_used (rx_desc_used),
      .irq          (irq),
      .rx_halt      (rx_halt),
      .module_on    (module_on)
   );

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ********
   // Helpers
   // ********
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Every access starts just after an edge, so strobes never collide
   task automatic bus_wr(logic [7:0] a, logic [31:0] d);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.be <= 4'hf;
      bus_req.wr <= 1'b1;
      @(posedge clock);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   task automatic bus_rd(logic [7:0] a, logic [3:0] b, output logic [31:0] d);
      bus_req.addr <= a;
      bus_req.be <= b;
      bus_req.rd <= 1'b1;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
      bus_rd(a, 4'hf, rd_val);
      chk(n, e, rd_val);
   endtask

   task automatic fire(logic [9:0] p, logic [7:0] n);
      evt <= {p[9:3], lvl};
      rx_desc_used <= n;
      @(posedge clock);
      evt <= {7'h00, lvl};
      #1;
   endtask

   task automatic set_lvl(logic [2:0] l);
      lvl = l;
      evt <= {7'h00, l};
      @(posedge clock);
      #1;
   endtask

   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      for (int a = 0; a <= 'h24; a += 4) begin
         rd_chk("reset value", 8'(a), 32'h0000_0000);
      end
      chk("reset outputs", 32'h0, {29'h0, irq, rx_halt, module_on});
   endtask

   task automatic t_flags();
      logic [9:0] src [5] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020};
      int         fb [5] = '{5, 3, 2, 1, 0};
      for (int i = 0; i < 5; i++) begin
         fire(src[i], 8'h00);
         rd_chk("flag set", `EIQ_OFF_FLAGS, 32'h1 << fb[i]);
         chk("irq masked", 32'h0, {31'h0, irq});
         bus_wr(`EIQ_OFF_IEN, 32'h1 << fb[i]);
         @(posedge clock);
         #1;
         chk("irq enabled", 32'h1, {31'h0, irq});
         bus_wr(`EIQ_OFF_CLR, 32'h1 << fb[i]);
         rd_chk("flag cleared", `EIQ_OFF_FLAGS, 32'h0);
         chk("irq after clear", 32'h0, {31'h0, irq});
         bus_wr(`EIQ_OFF_IEN, 32'h0);
      end
      bus_wr(`EIQ_OFF_FLAGS, 32'h40);
      rd_chk("pending write", `EIQ_OFF_FLAGS, 32'h0);
   endtask

   task automatic t_count();
      fire(10'h008, 8'h03);
      rd_chk("count add", `EIQ_OFF_STAT, 32'h0003_0000);
      rd_chk("pending", `EIQ_OFF_FLAGS, 32'h40);
      bus_wr(`EIQ_OFF_IEN, 32'h40);
      @(posedge clock);
      #1;
      chk("pending irq", 32'h1, {31'h0, irq});
      bus_wr(`EIQ_OFF_IEN, 32'h0);
      repeat (4) bus_wr(`EIQ_OFF_CTL, 32'h1);
      rd_chk("count floor", `EIQ_OFF_STAT, 32'h0);
      rd_chk("pending gone", `EIQ_OFF_FLAGS, 32'h0);
      fire(10'h008, 8'h02);
      // Decrement and increment meet at one edge
      bus_req.addr <= `EIQ_OFF_CTL;
      bus_req.wdata <= 32'h1;
      bus_req.wr <= 1'b1;
      evt <= {7'h01, lvl};
      rx_desc_used <= 8'h05;
      @(posedge clock);
      bus_req.wr <= 1'b0;
      evt <= {7'h00, lvl};
      #1;
      rd_chk("count same", `EIQ_OFF_STAT, 32'h0002_0000);
      fire(10'h008, 8'hfe);
      fire(10'h008, 8'h01);
      rd_chk("count sat", `EIQ_OFF_STAT, 32'h00ff_0000);
      chk("no flow halt", 32'h0, {31'h0, rx_halt});
      bus_wr(`EIQ_OFF_CTL, 32'h10);
      chk("flow halt", 32'h1, {31'h0, rx_halt});
      bus_wr(`EIQ_OFF_CTL, 32'h11);
      chk("halt release", 32'h0, {31'h0, rx_halt});
      bus_wr(`EIQ_OFF_CTL, 32'h8000);
      bus_wr(`EIQ_OFF_CTL, 32'h0);
      rd_chk("count kept off", `EIQ_OFF_STAT, 32'h00fe_0000);
      bus_wr(`EIQ_OFF_RXST, 32'h1234);
      rd_chk("count zeroed", `EIQ_OFF_STAT, 32'h0);
   endtask

   task automatic t_status();
      set_lvl(3'b011);
      rd_chk("busy while off", `EIQ_OFF_STAT, 32'h0);
      bus_wr(`EIQ_OFF_CTL, 32'h8000);
      chk("module on", 32'h1, {31'h0, module_on});
      rd_chk("busy while on", `EIQ_OFF_STAT, 32'h0000_00e0);
      set_lvl(3'b100);
      bus_wr(`EIQ_OFF_CTL, 32'h0);
      rd_chk("finishing", `EIQ_OFF_STAT, 32'h0000_0080);
      set_lvl(3'b000);
      rd_chk("idle", `EIQ_OFF_STAT, 32'h0);
   endtask

   task automatic t_drop();
      fire(10'h010, 8'h00);
      fire(10'h010, 8'h00);
      bus_rd(`EIQ_OFF_DROP, 4'hc, rd_val);
      chk("drop high lanes", 32'h2, rd_val);
      rd_chk("drop flag", `EIQ_OFF_FLAGS, 32'h1);
      bus_rd(`EIQ_OFF_DROP, 4'h1, rd_val);
      chk("drop low lane", 32'h2, rd_val);
      rd_chk("drop cleared", `EIQ_OFF_DROP, 32'h0);
      bus_wr(`EIQ_OFF_CLR, 32'h1);
   endtask

   task automatic t_alias();
      bus_wr(`EIQ_OFF_SET, 32'h8);
      rd_chk("set alias", `EIQ_OFF_FLAGS, 32'h8);
      @(posedge clock);
      #1;
      chk("read data one cycle", 32'h0, bus_rdata);
      bus_wr(`EIQ_OFF_INV, 32'h9);
      rd_chk("invert alias", `EIQ_OFF_FLAGS, 32'h1);
      // Clear and transmit done meet at one edge
      bus_req.addr <= `EIQ_OFF_CLR;
      bus_req.wdata <= 32'h9;
      bus_req.wr <= 1'b1;
      evt <= {7'h20, lvl};
      @(posedge clock);
      bus_req.wr <= 1'b0;
      evt <= {7'h00, lvl};
      #1;
      rd_chk("set beats clear", `EIQ_OFF_FLAGS, 32'h8);
      bus_wr(`EIQ_OFF_CLR, 32'h8);
      bus_wr(`EIQ_OFF_DROP, 32'h0000_1234);
      bus_rd(`EIQ_OFF_DROP, 4'hc, rd_val);
      chk("drop write", 32'h1234, rd_val);
      rd_chk("drop read", `EIQ_OFF_DROP, 32'h1234);
      rd_chk("drop after read", `EIQ_OFF_DROP, 32'h0);
      bus_wr(`EIQ_OFF_STAT, 32'h0042_0000);
      rd_chk("count write", `EIQ_OFF_STAT, 32'h0042_0000);
      bus_wr(`EIQ_OFF_RXST, 32'h0);
      rd_chk("count cleared", `EIQ_OFF_STAT, 32'h0);
   endtask

   // ********
   // Sequence
   // ********
   initial begin
      #200000;
      failures++;
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      bus_req = '0;
      evt = '0;
      rx_desc_used = 8'h00;
      lvl = 3'b000;
      failures = 0;
      comparisons = 0;
      repeat (2) @(posedge clock);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_flags();
      t_count();
      t_status();
      t_drop();
      t_alias();
      summarize();
   end
endmodule
